// ===== hw/ubp_top.sv
// serial port baud chain, parity, mute/wake and 16x sampling receiver
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Function
// - tx and rx rates derived independently
// - prescale field selects 1, 3, 4, 13
// - per-direction power-of-two divisor 1..128
// - fine prescaler only when register non-zero
// - fine factor further divides each direction
// - muted receiver sets no flags, no irq
// - idle frame wakes, clears mute, no idle
// - address mark wakes and delivers word
// - frame format from length and parity
// - parity enable covers transmit and receive
// - wake examines top data bit, not parity
// - even or odd parity per select
// - transmit replaces top bit by parity
// - parity failure sets flag, may interrupt
// - bit value is majority of 8,9,10
// - data bit noise when samples differ
// - sample counter restarts on each start
// - invalid falling edge flags noise
// - start noise when sample 8-10 high
// - wait runs normally; halt freezes all
// - lsb first, start low, stop high
// - all-ones idle, break gives framing error
// - false start noise held for next frame
module ubp_top
    import ubp_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // power mode
    input  wire logic        halt_mode,
    // serial line
    input  wire logic        serial_in_pin,
    output logic             serial_out,
    output logic             irq_request
);
    typedef struct packed {
        logic [3:0]       ps_cnt;
        logic [1:0][6:0]  dv_cnt;
        logic [1:0][7:0]  fn_cnt;
        logic [7:0]       baud_config_reg;
        logic [7:0]       tx_fine_prescale_reg;
        logic [7:0]       rx_fine_prescale_reg;
        logic [7:0]       control_reg_one;
        logic [7:0]       control_reg_two;
        logic [7:0]       status_reg;
        logic             armed;
        logic             noise_hold;
        logic             idle_armed;
        ubp_rx_type       rx_st;
        logic [3:0]       rx_smp;
        logic [3:0]       rx_bit;
        logic [8:0]       rx_sh;
        logic [1:0]       rx_trio;
        logic [2:0]       rx_hist;
        logic             rx_noise;
        logic [7:0]       idle_cnt;
        logic [8:0]       rx_buf;
        ubp_tx_type       tx_st;
        logic [3:0]       tx_smp;
        logic [3:0]       tx_bit;
        logic [10:0]      tx_sh;
        logic [8:0]       tx_buf;
        logic             tx_full;
        logic             tx_pre;
        logic             tx_data;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
    } ubp_state_type;

    ubp_state_type    st_r;
    ubp_state_type    st_nxt;
    logic [3:0]       pr_top;
    logic             pre_tick;
    logic [1:0]       pow_tick;
    logic [1:0]       dir_tick;
    logic [1:0][2:0]  dsel;
    logic [1:0][6:0]  div_top;
    logic [1:0][7:0]  fine_reg;
    logic             long_w;
    logic             pen;
    logic             psel;
    logic             muted;
    logic [3:0]       frame_bits;
    logic [7:0]       idle_ticks;
    logic [2:0]       trio;
    logic             bitv;
    logic [8:0]       word;
    logic             msb;
    logic             par_err;
    logic [8:0]       tw;
    logic             wr_go;
    logic             rd_go;

    assign long_w     = st_r.control_reg_one[CR1_LONG];
    assign pen        = st_r.control_reg_one[CR1_PEN];
    assign psel       = st_r.control_reg_one[CR1_PSEL];
    assign muted      = st_r.control_reg_two[CR2_MUTE];
    assign frame_bits = long_w ? FRAME_LONG : FRAME_SHORT;
    assign idle_ticks = {4'h0, frame_bits} * OVERSAMPLE;

    always_comb
    begin
        case (st_r.baud_config_reg[PSEL_LSB+:2])
            2'b00:   pr_top = PR_F0 - 4'h1;
            2'b01:   pr_top = PR_F1 - 4'h1;
            2'b10:   pr_top = PR_F2 - 4'h1;
            default: pr_top = PR_F3 - 4'h1;
        endcase
    end
    assign pre_tick = (st_r.ps_cnt == pr_top);

    assign dsel[DIR_TX]     = st_r.baud_config_reg[TXD_LSB+:3];
    assign dsel[DIR_RX]     = st_r.baud_config_reg[RXD_LSB+:3];
    assign fine_reg[DIR_TX] = st_r.tx_fine_prescale_reg;
    assign fine_reg[DIR_RX] = st_r.rx_fine_prescale_reg;

    // the 16x pulse is the sampling clock; the bit clock divides it by 16
    for (genvar d = 0; d < 2; d++)
    begin : g_dir
        assign div_top[d]  = 7'((8'h01 << dsel[d]) - 8'h01);
        assign pow_tick[d] = pre_tick && (st_r.dv_cnt[d] == div_top[d]);
        assign dir_tick[d] = (fine_reg[d] == 8'h00) ? pow_tick[d]
            : pow_tick[d] && (st_r.fn_cnt[d] == fine_reg[d] - 8'h01);
    end

    assign trio    = {st_r.rx_trio, serial_in_pin};
    assign bitv    = ubp_maj3(trio);
    assign word    = long_w ? st_r.rx_sh : {1'b0, st_r.rx_sh[8:1]};
    assign msb     = word[4'(6 + {3'b0, long_w} + {3'b0, !pen})];
    assign par_err = (long_w ? ^word : ^word[7:0]) ^ psel;

    always_comb
    begin
        tw = wdata[8:0];
        if (pen && long_w)
            tw[8] = ^wdata[7:0] ^ psel;
        else if (pen)
            tw[7] = ^wdata[6:0] ^ psel;
    end

    assign wr_go = awvalid && wvalid && !st_r.bvalid && !halt_mode;
    assign rd_go = arvalid && !st_r.rvalid && !halt_mode;

    always_comb
    begin
        st_nxt = st_r;
        // baud chain
        st_nxt.ps_cnt = pre_tick ? 4'h0 : st_r.ps_cnt + 4'h1;
        for (int d = 0; d < 2; d++)
        begin
            if (pre_tick)
                st_nxt.dv_cnt[d] = pow_tick[d] ? 7'h00
                                 : st_r.dv_cnt[d] + 7'h01;
            if (pow_tick[d])
                st_nxt.fn_cnt[d] = dir_tick[d] ? 8'h00
                                 : st_r.fn_cnt[d] + 8'h01;
        end
        // bus: clears come first so a same-cycle hardware set wins
        if (st_r.bvalid && bready)
            st_nxt.bvalid = 1'b0;
        if (st_r.rvalid && rready)
            st_nxt.rvalid = 1'b0;
        if (wr_go)
        begin
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = RESP_OKAY;
            case (awaddr)
                ADDR_BAUD:   if (wstrb[0]) st_nxt.baud_config_reg = wdata[7:0];
                ADDR_TXFINE: if (wstrb[0]) st_nxt.tx_fine_prescale_reg = wdata[7:0];
                ADDR_RXFINE: if (wstrb[0]) st_nxt.rx_fine_prescale_reg = wdata[7:0];
                ADDR_CR1:    if (wstrb[0]) st_nxt.control_reg_one = wdata[7:0];
                ADDR_CR2:
                    if (wstrb[0])
                    begin
                        st_nxt.control_reg_two = wdata[7:0];
                        if (wdata[CR2_TE] && !st_r.control_reg_two[CR2_TE])
                            st_nxt.tx_pre = 1'b1;
                    end
                ADDR_STATUS: st_nxt.bresp = RESP_OKAY;
                ADDR_DATA:
                    if (wstrb[0])
                    begin
                        if (st_r.armed)
                            st_nxt.status_reg[ST_TC] = 1'b0;
                        st_nxt.armed = 1'b0;
                        if (!st_r.tx_full)
                        begin
                            st_nxt.tx_buf = tw;
                            st_nxt.tx_full = 1'b1;
                            st_nxt.status_reg[ST_TXE] = 1'b0;
                        end
                    end
                default: st_nxt.bresp = RESP_SLVERR;
            endcase
            // a count past its new end value would first run a full wrap
            if (wstrb[0] && awaddr inside {ADDR_BAUD, ADDR_TXFINE,
                ADDR_RXFINE})
            begin
                st_nxt.ps_cnt = 4'h0;
                st_nxt.dv_cnt = '0;
                st_nxt.fn_cnt = '0;
            end
        end
        if (rd_go)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = RESP_OKAY;
            st_nxt.rdata  = 32'h0000_0000;
            case (araddr)
                ADDR_BAUD:   st_nxt.rdata[7:0] = st_r.baud_config_reg;
                ADDR_TXFINE: st_nxt.rdata[7:0] = st_r.tx_fine_prescale_reg;
                ADDR_RXFINE: st_nxt.rdata[7:0] = st_r.rx_fine_prescale_reg;
                ADDR_CR1:    st_nxt.rdata[7:0] = st_r.control_reg_one;
                ADDR_CR2:    st_nxt.rdata[7:0] = st_r.control_reg_two;
                ADDR_STATUS:
                begin
                    st_nxt.rdata[7:0] = st_r.status_reg;
                    st_nxt.armed = 1'b1;
                end
                ADDR_DATA:
                begin
                    st_nxt.rdata[8:0] = st_r.rx_buf;
                    if (st_r.armed)
                        st_nxt.status_reg[5:0] = 6'h00;
                    st_nxt.armed = 1'b0;
                end
                default: st_nxt.rresp = RESP_SLVERR;
            endcase
        end
        // receiver on the 16x receive pulse
        if (dir_tick[DIR_RX] && st_r.control_reg_two[CR2_RE])
        begin
            st_nxt.rx_smp = st_r.rx_smp + 4'h1;
            if (st_r.rx_smp == SMP_IDX_8 || st_r.rx_smp == SMP_IDX_9)
                st_nxt.rx_trio = {st_r.rx_trio[0], serial_in_pin};
            case (st_r.rx_st)
                RX_IDLE:
                begin
                    st_nxt.rx_hist = {st_r.rx_hist[1:0], serial_in_pin};
                    if (!serial_in_pin)
                    begin
                        st_nxt.rx_st = RX_START;
                        st_nxt.rx_smp = 4'h1;
                        st_nxt.rx_noise = (st_r.rx_hist != 3'b111);
                        st_nxt.idle_cnt = 8'h00;
                    end
                    else if (st_r.idle_cnt != idle_ticks)
                        st_nxt.idle_cnt = st_r.idle_cnt + 8'h01;
                    if (serial_in_pin && st_r.idle_cnt == idle_ticks - 8'h01)
                    begin
                        if (muted && !st_r.control_reg_two[CR2_WAKE])
                            st_nxt.control_reg_two[CR2_MUTE] = 1'b0;
                        else if (!muted && st_r.idle_armed)
                        begin
                            st_nxt.status_reg[ST_IDLE] = 1'b1;
                            st_nxt.idle_armed = 1'b0;
                        end
                    end
                end
                RX_START:
                begin
                    if ((st_r.rx_smp == SMP_IDX_3 || st_r.rx_smp == SMP_IDX_5 ||
                         st_r.rx_smp == SMP_IDX_7) && serial_in_pin)
                        st_nxt.rx_noise = 1'b1;
                    if (st_r.rx_smp == SMP_IDX_10)
                    begin
                        if (bitv)
                        begin
                            st_nxt.noise_hold = 1'b1;
                            st_nxt.rx_st = RX_IDLE;
                            st_nxt.rx_hist = 3'b000;
                        end
                        else if (trio != 3'b000)
                            st_nxt.rx_noise = 1'b1;
                    end
                    if (st_r.rx_smp == SMP_IDX_16)
                    begin
                        st_nxt.rx_st = RX_DATA;
                        st_nxt.rx_bit = 4'h0;
                    end
                end
                RX_DATA:
                begin
                    if (st_r.rx_smp == SMP_IDX_10)
                    begin
                        st_nxt.rx_sh = {bitv, st_r.rx_sh[8:1]};
                        if (trio != 3'b000 && trio != 3'b111)
                            st_nxt.rx_noise = 1'b1;
                    end
                    if (st_r.rx_smp == SMP_IDX_16)
                    begin
                        st_nxt.rx_bit = st_r.rx_bit + 4'h1;
                        if (st_r.rx_bit == frame_bits - 4'h3)
                            st_nxt.rx_st = RX_STOP;
                    end
                end
                RX_STOP:
                    if (st_r.rx_smp == SMP_IDX_10)
                    begin
                        st_nxt.rx_st = RX_IDLE;
                        st_nxt.rx_hist = {3{bitv}};
                        st_nxt.idle_cnt = 8'h00;
                        if (muted && st_r.control_reg_two[CR2_WAKE] && msb)
                            st_nxt.control_reg_two[CR2_MUTE] = 1'b0;
                        // a muted receiver discards the frame whole unless it is an address mark
                        if (!muted || (st_r.control_reg_two[CR2_WAKE] && msb))
                        begin
                            st_nxt.idle_armed = 1'b1;
                            if (st_r.status_reg[ST_RDY])
                                st_nxt.status_reg[ST_OVR] = 1'b1;
                            else
                            begin
                                st_nxt.rx_buf = word;
                                st_nxt.status_reg[ST_RDY] = 1'b1;
                                st_nxt.status_reg[ST_NF] =
                                    st_r.rx_noise || st_r.noise_hold;
                                st_nxt.noise_hold = 1'b0;
                                st_nxt.status_reg[ST_FE] = !bitv;
                                st_nxt.status_reg[ST_PE] =
                                    pen && par_err;
                            end
                        end
                    end
                default: st_nxt.rx_st = RX_IDLE;
            endcase
        end
        // transmitter on the 16x transmit pulse
        if (dir_tick[DIR_TX] && st_r.control_reg_two[CR2_TE])
        begin
            case (st_r.tx_st)
                TX_IDLE:
                begin
                    st_nxt.tx_smp = 4'h0;
                    st_nxt.tx_bit = 4'h0;
                    if (st_r.tx_pre)
                    begin
                        st_nxt.tx_pre = 1'b0;
                        st_nxt.tx_data = 1'b0;
                        st_nxt.tx_st = TX_SEND;
                        st_nxt.tx_sh = 11'h7FF;
                    end
                    else if (st_r.tx_full)
                    begin
                        st_nxt.tx_full = 1'b0;
                        st_nxt.tx_data = 1'b1;
                        st_nxt.status_reg[ST_TXE] = 1'b1;
                        st_nxt.tx_st = TX_SEND;
                        st_nxt.tx_sh = long_w ? {1'b1, st_r.tx_buf, 1'b0}
                            : {2'b11, st_r.tx_buf[7:0], 1'b0};
                    end
                end
                TX_SEND:
                begin
                    st_nxt.tx_smp = st_r.tx_smp + 4'h1;
                    if (st_r.tx_smp == SMP_IDX_16)
                    begin
                        st_nxt.tx_sh = {1'b1, st_r.tx_sh[10:1]};
                        st_nxt.tx_bit = st_r.tx_bit + 4'h1;
                        if (st_r.tx_bit == frame_bits - 4'h1)
                        begin
                            st_nxt.tx_st = TX_IDLE;
                            if (st_r.tx_data)
                                st_nxt.status_reg[ST_TC] = 1'b1;
                        end
                    end
                end
                default: st_nxt.tx_st = TX_IDLE;
            endcase
        end
        // halt freezes every register; wait needs no logic at all
        if (halt_mode)
            st_nxt = st_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r            <= '0;
            st_r.status_reg <= STATUS_RST;
            st_r.tx_sh      <= 11'h7FF;
            st_r.rx_hist    <= 3'h7;
        end
        else
            st_r <= st_nxt;
    end

    assign awready    = wr_go;
    assign wready     = wr_go;
    assign arready    = !st_r.rvalid && !halt_mode;
    assign bvalid     = st_r.bvalid;
    assign bresp      = st_r.bresp;
    assign rvalid     = st_r.rvalid;
    assign rresp      = st_r.rresp;
    assign rdata      = st_r.rdata;
    assign serial_out = st_r.tx_sh[0];
    assign irq_request = (st_r.control_reg_two[CR2_RIE] &&
        (st_r.status_reg[ST_RDY] || st_r.status_reg[ST_OVR])) ||
        (st_r.control_reg_two[CR2_ILIE] && st_r.status_reg[ST_IDLE]) ||
        (st_r.control_reg_one[CR1_PIE] && st_r.status_reg[ST_PE]);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_prescale_thirteen: assert property (
        (pre_tick && st_r.baud_config_reg[PSEL_LSB+:2] == 2'b11
         && !halt_mode) |=>
        (!pre_tick || st_r.baud_config_reg[PSEL_LSB+:2] != 2'b11)[*8])
        else $error("prescale 13 pulse too early");
    a_fine_gates_tick: assert property (
        dir_tick[DIR_TX] |-> pow_tick[DIR_TX])
        else $error("fine tick without divider tick");
    a_conv_rate_direct: assert property (
        (st_r.rx_fine_prescale_reg == 8'h00) |->
        (dir_tick[DIR_RX] == pow_tick[DIR_RX]))
        else $error("fine stage active at zero");
    a_divider_range: assert property (
        $stable(st_r.baud_config_reg) |->
        st_r.dv_cnt[DIR_TX] <= div_top[DIR_TX])
        else $error("divider counter out of range");
    a_mute_no_flags: assert property (
        (muted && !st_r.control_reg_two[CR2_WAKE]) |=>
        !$rose(st_r.status_reg[ST_RDY]))
        else $error("muted receiver set ready");
    a_idle_wake_clear: assert property (
        ($fell(st_r.control_reg_two[CR2_MUTE]) &&
         !$past(st_r.control_reg_two[CR2_WAKE]) && !$past(wr_go))
        |-> !$rose(st_r.status_reg[ST_IDLE]))
        else $error("idle flag set on wake");
    a_tx_start_low: assert property (
        ($rose(st_r.tx_st == TX_SEND) && st_r.tx_data) |-> !serial_out)
        else $error("start bit not low");
    a_halt_freeze: assert property (
        halt_mode |=> $stable(st_r.status_reg) && $stable(st_r.rx_st))
        else $error("state moved in halt");
    a_parity_needs_en: assert property (
        $rose(st_r.status_reg[ST_PE]) |-> $past(pen))
        else $error("parity error without enable");
    a_noise_with_ready: assert property (
        $rose(st_r.status_reg[ST_NF]) |-> $rose(st_r.status_reg[ST_RDY]))
        else $error("noise flag without ready");
endmodule // ubp_top

// ===== shared/ubp_pkg.sv
// constants, field layout and state codes of the serial baud/sampling block
package ubp_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_BAUD   = 8'h00;
    localparam logic [7:0] ADDR_TXFINE = 8'h04;
    localparam logic [7:0] ADDR_RXFINE = 8'h08;
    localparam logic [7:0] ADDR_CR1    = 8'h0C;
    localparam logic [7:0] ADDR_CR2    = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_DATA   = 8'h18;
    // baud_config_reg fields
    localparam int PSEL_LSB = 6;
    localparam int TXD_LSB  = 3;
    localparam int RXD_LSB  = 0;
    // control_reg_one bits
    localparam int CR1_LONG = 4;
    localparam int CR1_PEN  = 2;
    localparam int CR1_PSEL = 1;
    localparam int CR1_PIE  = 0;
    // control_reg_two bits
    localparam int CR2_RIE  = 5;
    localparam int CR2_ILIE = 4;
    localparam int CR2_TE   = 3;
    localparam int CR2_RE   = 2;
    localparam int CR2_MUTE = 1;
    localparam int CR2_WAKE = 0;
    // status_reg bits
    localparam int ST_TXE  = 7;
    localparam int ST_TC   = 6;
    localparam int ST_RDY  = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OVR  = 3;
    localparam int ST_NF   = 2;
    localparam int ST_FE   = 1;
    localparam int ST_PE   = 0;
    localparam logic [7:0] STATUS_RST = 8'hC0;
    // common prescale factors
    localparam logic [3:0] PR_F0 = 4'h1;
    localparam logic [3:0] PR_F1 = 4'h3;
    localparam logic [3:0] PR_F2 = 4'h4;
    localparam logic [3:0] PR_F3 = 4'hD;
    // direction index
    localparam int DIR_TX = 0;
    localparam int DIR_RX = 1;
    // oversampling: sample number is index plus one
    localparam logic [7:0] OVERSAMPLE = 8'h10;
    localparam logic [3:0] SMP_IDX_3  = 4'h2;
    localparam logic [3:0] SMP_IDX_5  = 4'h4;
    localparam logic [3:0] SMP_IDX_7  = 4'h6;
    localparam logic [3:0] SMP_IDX_8  = 4'h7;
    localparam logic [3:0] SMP_IDX_9  = 4'h8;
    localparam logic [3:0] SMP_IDX_10 = 4'h9;
    localparam logic [3:0] SMP_IDX_16 = 4'hF;
    // frame lengths in bits, start and stop included
    localparam logic [3:0] FRAME_SHORT = 4'hA;
    localparam logic [3:0] FRAME_LONG  = 4'hB;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } ubp_rx_type;
    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } ubp_tx_type;
    function automatic logic ubp_maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction
endpackage

// ===== verif/ubp_remote_node.sv
// remote serial node: drives the receive line, catches transmit frames
`timescale 1ns/1ps
module ubp_remote_node (
    // clock
    input  wire logic aclk,
    // serial lines
    input  wire logic serial_out,
    output logic      serial_in_pin
);
    initial serial_in_pin = 1'b1;
    // start low, lsb first, stop high; line rests high after it
    task automatic send(input logic [8:0] w, input int n, input int bt);
        @(posedge aclk);
        for (int i = 0; i < n + 2; i++)
        begin
            serial_in_pin <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : w[i - 1];
            repeat (bt) @(posedge aclk);
        end
    endtask
    // mid-bit sampling; an idle frame has no falling edge, so it is skipped
    task automatic catch(output logic [9:0] f, input int bt);
        @(negedge serial_out);
        repeat (bt / 2) @(posedge aclk);
        for (int i = 0; i < 10; i++)
        begin
            f[i] = serial_out;
            repeat (bt) @(posedge aclk);
        end
    endtask
endmodule // ubp_remote_node

// ===== verif/ubp_top_tb.sv
// self-checking bench for the serial baud, parity and sampling block
`timescale 1ns/1ps
module ubp_top_tb import ubp_pkg::*;;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, halt_mode;
    logic        serial_in_pin, serial_out, irq_request;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [9:0]  fr;
    int          num_errors, cmp_count;
    ubp_top i_ubp_top (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .halt_mode, .serial_in_pin, .serial_out, .irq_request);
    ubp_remote_node i_ubp_remote_node (.aclk, .serial_out, .serial_in_pin);
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask
    // readiness is looked at on the falling edge, so it is settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(negedge aclk); while (!awready);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        bready  <= 1'b1;
        do @(negedge aclk); while (!bvalid);
        @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(negedge aclk); while (!rvalid);
        @(posedge aclk);
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    // baud changes only with both directions off
    task automatic rx_case(input logic [7:0] baud, input logic [7:0] fine,
                           input logic [8:0] w, input int n, input int bt);
        wr(ADDR_CR2, 32'h00, rsp);
        wr(ADDR_BAUD, {24'h0, baud}, rsp);
        wr(ADDR_RXFINE, {24'h0, fine}, rsp);
        wr(ADDR_CR2, 32'h04, rsp);
        i_ubp_remote_node.send(w, n, bt);
        rd(ADDR_STATUS, rv);
        chk(rv[ST_RDY], 1'b1);
        rd(ADDR_DATA, rv);
        chk(rv, {23'h0, w});
    endtask
    task automatic t_parity;
        wr(ADDR_CR2, 32'h04, rsp);
        wr(ADDR_CR1, 32'h05, rsp);
        i_ubp_remote_node.send(9'h0B5, 8, 16);
        rd(ADDR_STATUS, rv);
        chk(rv[ST_PE], 1'b1);
        chk(irq_request, 1'b1);
        rd(ADDR_DATA, rv);
        wr(ADDR_CR1, 32'h07, rsp);
        i_ubp_remote_node.send(9'h0B5, 8, 16);
        rd(ADDR_STATUS, rv);
        chk(rv[ST_PE], 1'b0);
        chk(irq_request, 1'b0);
        rd(ADDR_DATA, rv);
    endtask
    task automatic t_tx;
        wr(ADDR_CR1, 32'h05, rsp);
        wr(ADDR_CR2, 32'h0C, rsp);
        fork
            i_ubp_remote_node.catch(fr, 16);
            wr(ADDR_DATA, 32'hB5, rsp);
        join
        chk(fr, 10'h26A);
    endtask
    task automatic t_mute;
        wr(ADDR_CR1, 32'h00, rsp);
        // wake bit clear: only an idle line unmutes
        wr(ADDR_CR2, 32'h06, rsp);
        i_ubp_remote_node.send(9'h092, 8, 16);
        rd(ADDR_STATUS, rv);
        chk(rv[ST_RDY], 1'b0);
        rd(ADDR_DATA, rv);
        repeat (200) @(posedge aclk);
        rd(ADDR_CR2, rv);
        chk(rv[CR2_MUTE], 1'b0);
        rd(ADDR_STATUS, rv);
        chk(rv[ST_IDLE], 1'b0);
        wr(ADDR_CR2, 32'h07, rsp);
        i_ubp_remote_node.send(9'h012, 8, 16);
        rd(ADDR_STATUS, rv);
        chk(rv[ST_RDY], 1'b0);
        i_ubp_remote_node.send(9'h092, 8, 16);
        rd(ADDR_CR2, rv);
        chk(rv[CR2_MUTE], 1'b0);
        rd(ADDR_STATUS, rv);
        chk(rv[ST_RDY], 1'b1);
        rd(ADDR_DATA, rv);
        chk(rv, 32'h92);
    endtask
    // a short low pulse is a false start; its noise shows next frame
    task automatic t_noise;
        i_ubp_remote_node.send(9'h000, 0, 4);
        repeat (32) @(posedge aclk);
        i_ubp_remote_node.send(9'h05A, 8, 16);
        rd(ADDR_STATUS, rv);
        chk({rv[ST_RDY], rv[ST_NF]}, 2'h3);
        rd(ADDR_DATA, rv);
        chk(rv, 32'h5A);
    endtask
    task automatic t_rates;
        rx_case(8'h38, 8'h00, 9'h0A5, 8, 16);
        rx_case(8'h40, 8'h00, 9'h05A, 8, 48);
        rx_case(8'h80, 8'h00, 9'h0C3, 8, 64);
        rx_case(8'hC0, 8'h00, 9'h03C, 8, 208);
        rx_case(8'h01, 8'h00, 9'h081, 8, 32);
        rx_case(8'h00, 8'h03, 9'h07E, 8, 48);
        wr(ADDR_CR1, 32'h10, rsp);
        rx_case(8'h00, 8'h00, 9'h1A5, 9, 16);
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // whole run is near 6000 cycles; this is over fifteen times that
    initial
    begin
        #1_000_000;
        num_errors++;
        wrap_up;
    end
    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, halt_mode} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_STATUS, rv);
        chk(rv, {24'h0, STATUS_RST});
        wr(8'h40, 32'h0, rsp);
        chk(rsp, RESP_SLVERR);
        rd(8'h40, rv);
        chk(rsp, RESP_SLVERR);
        halt_mode <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(arready, 1'b0);
        halt_mode <= 1'b0;
        t_parity;
        t_tx;
        t_mute;
        t_noise;
        t_rates;
        wrap_up;
    end
endmodule // ubp_top_tb
